/* File: exec_unit_pkg.sv */
// Shared types and constants for the instruction execution unit
package exec_unit_pkg;

  // Operations offered by the core's decoder
  typedef enum logic [4:0] {
    op_nop,
    op_rotate_right_carry_to_acc,
    op_subtract_with_borrow,
    op_subtract_with_borrow_to_mem,
    op_decrement_skip_zero,
    op_decrement_to_acc_skip_zero,
    op_set_byte,
    op_set_bit,
    op_increment_skip_zero,
    op_increment_to_acc_skip_zero,
    op_skip_bit_nonzero,
    op_subtract,
    op_subtract_imm,
    op_subtract_to_mem,
    op_nibble_swap,
    op_nibble_swap_to_acc,
    op_skip_if_zero,
    op_move_and_skip_zero,
    op_skip_bit_zero,
    op_table_read_specific_page,
    op_table_read_current_page,
    op_table_read_last_page,
    op_exclusive_or,
    op_exclusive_or_imm,
    op_exclusive_or_to_mem
  } instr_op_type;

  typedef struct packed {
    instr_op_type op;
    logic [7:0]   addr;
    logic [2:0]   bit_sel;
    logic [7:0]   imm;
  } issue_type;

  typedef struct packed {
    logic overflow_flag;
    logic zero_flag;
    logic aux_carry_flag;
    logic carry_flag;
  } flags_type;

  typedef enum logic [1:0] {st_idle, st_table_fetch, st_table_capture} exec_state_type;

  // Register map, byte addresses on the bus
  localparam int            APB_ADDR_W    = 12;
  localparam logic [11:0]   ACC_OFFSET    = 12'h000;
  localparam logic [11:0]   FLAGS_OFFSET  = 12'h004;
  localparam logic [11:0]   TPTR_OFFSET   = 12'h008;
  localparam logic [11:0]   TABLE_READ_HIGH_BYTE_OFFSET   = 12'h00c;
  localparam logic [11:0]   STATE_OFFSET  = 12'h010;
  localparam logic [1:0]    DMEM_REGION   = 2'h1;
  localparam int            DMEM_REGION_LSB = 10;

  // Field positions
  localparam int            TPTR_LOW_LSB  = 0;
  localparam int            TPTR_HIGH_LSB = 8;
  localparam int            STATE_READY_BIT  = 0;
  localparam int            STATE_SQUASH_BIT = 1;

  // Reset values and fixed data
  localparam logic [7:0]    ACC_RESET     = 8'h00;
  localparam flags_type     FLAGS_RESET   = 4'h0;
  localparam logic [7:0]    TPTR_RESET    = 8'h00;
  localparam logic [7:0]    BYTE_ONES     = 8'hff;
  localparam logic [7:0]    BYTE_ZERO     = 8'h00;
  localparam logic [7:0]    BYTE_ONE      = 8'h01;
  localparam logic [31:0]   WORD_ZERO     = 32'h0000_0000;

endpackage : exec_unit_pkg

/* File: instr_exec_unit.sv */
// Execution unit for rotate, subtract, skip, set, swap, XOR and table-read operations
//
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
module instr_exec_unit
  import exec_unit_pkg::*;
#(
  parameter int PM_ADDR_W  = 12,
  parameter int PM_DATA_W  = 16,
  parameter int DMEM_DEPTH = 256
) (
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [APB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  op_valid,
  input  wire issue_type             op_issue,
  input  wire logic [PM_ADDR_W-9:0]  pc_page,
  output logic                       op_ready,
  output logic                       skip_taken,
  output logic                       op_squashed,
  output logic                       pm_rd_en,
  output logic      [PM_ADDR_W-1:0]  pm_addr,
  input  wire logic [PM_DATA_W-1:0]  pm_rdata,
  output logic      [7:0]            accumulator,
  output flags_type                  flags,
  output logic      [PM_DATA_W-9:0]  table_read_high_byte
);

  localparam logic [PM_ADDR_W-9:0] LAST_PAGE = '1;

  logic [7:0]           dmem [DMEM_DEPTH];
  logic [7:0]           accumulator_reg;
  flags_type            flags_reg;
  logic [7:0]           table_pointer_low;
  logic [PM_ADDR_W-9:0] table_pointer_high;
  logic [PM_DATA_W-9:0] table_read_high_byte_reg;
  exec_state_type       state_reg;
  logic                 squash_pending_reg;
  logic                 op_ready_reg;
  logic                 skip_taken_reg;
  logic                 op_squashed_reg;
  logic                 pm_rd_en_reg;
  logic [PM_ADDR_W-1:0] pm_addr_reg;
  logic [7:0]           table_dest_reg;
  logic [31:0]          prdata_reg;
  logic                 pready_reg;
  logic                 pslverr_reg;

  // Subtract with flags: a - b - borrow_in
  function automatic logic [11:0] subtract_flags(input logic [7:0] a, input logic [7:0] b,
                                                input logic borrow_in);
    logic [8:0] diff;
    logic [4:0] low;
    diff = {1'b0, a} - {1'b0, b} - {8'h00, borrow_in};
    low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, borrow_in};
    // Result, then overflow, zero, aux carry, carry (carry is no-borrow)
    return {diff[7:0], (a[7] ^ b[7]) & (a[7] ^ diff[7]), diff[7:0] == BYTE_ZERO,
            ~low[4], ~diff[8]};
  endfunction

  function automatic logic is_reg(input logic [APB_ADDR_W-1:0] a, input logic [11:0] off);
    return a == off;
  endfunction

  // Operand fetch and decode
  logic        accept;
  logic        execute;
  logic        bus_write;
  logic [7:0]  operand;
  logic        sel_bit;
  logic [11:0] sub_res;
  logic [7:0]  dec_val;
  logic [7:0]  inc_val;
  logic [7:0]  xor_val;
  logic [7:0]  swap_val;

  assign accept    = op_valid & op_ready_reg;
  assign execute   = accept & ~squash_pending_reg;
  assign bus_write = psel & penable & pready_reg & pwrite;
  assign operand   = dmem[op_issue.addr];
  assign sel_bit   = operand[op_issue.bit_sel];
  assign dec_val   = operand - BYTE_ONE;
  assign inc_val   = operand + BYTE_ONE;
  assign xor_val   = accumulator_reg ^ ((op_issue.op == op_exclusive_or_imm) ? op_issue.imm
                                                                            : operand);
  assign swap_val  = {operand[3:0], operand[7:4]};

  // Borrow-in is the inverted carry only for the with-borrow forms
  always_comb begin
    logic [7:0] sub_b;
    logic       sub_bin;
    sub_b   = (op_issue.op == op_subtract_imm) ? op_issue.imm : operand;
    sub_bin = (op_issue.op == op_subtract_with_borrow ||
               op_issue.op == op_subtract_with_borrow_to_mem) ? ~flags_reg.carry_flag : 1'b0;
    sub_res = subtract_flags(accumulator_reg, sub_b, sub_bin);
  end

  // Skip decision
  logic skip_now;
  always_comb begin
    unique case (op_issue.op)
      op_decrement_skip_zero, op_decrement_to_acc_skip_zero: skip_now = dec_val == BYTE_ZERO;
      op_increment_skip_zero, op_increment_to_acc_skip_zero: skip_now = inc_val == BYTE_ZERO;
      op_skip_bit_nonzero:                                   skip_now = sel_bit;
      op_skip_bit_zero:                                      skip_now = ~sel_bit;
      op_skip_if_zero, op_move_and_skip_zero:                skip_now = operand == BYTE_ZERO;
      default:                                               skip_now = 1'b0;
    endcase
  end

  // Accumulator and flags
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      accumulator_reg <= ACC_RESET;
      flags_reg       <= FLAGS_RESET;
    end else begin
      if (execute) begin
        unique case (op_issue.op)
          op_rotate_right_carry_to_acc: begin
            accumulator_reg      <= {flags_reg.carry_flag, operand[7:1]};
            flags_reg.carry_flag <= operand[0];
          end
          op_subtract_with_borrow, op_subtract, op_subtract_imm: begin
            accumulator_reg <= sub_res[11:4];
            flags_reg       <= sub_res[3:0];
          end
          // subtract into memory, flags only here
          op_subtract_with_borrow_to_mem, op_subtract_to_mem: flags_reg <= sub_res[3:0];
          op_decrement_to_acc_skip_zero: accumulator_reg <= dec_val;
          op_increment_to_acc_skip_zero: accumulator_reg <= inc_val;
          op_nibble_swap_to_acc: accumulator_reg <= swap_val;
          op_move_and_skip_zero: accumulator_reg <= operand;
          op_exclusive_or, op_exclusive_or_imm: begin
            accumulator_reg     <= xor_val;
            flags_reg.zero_flag <= xor_val == BYTE_ZERO;
          end
          op_exclusive_or_to_mem: flags_reg.zero_flag <= xor_val == BYTE_ZERO;
          default: ;
        endcase
      end
      if (bus_write && is_reg(paddr, ACC_OFFSET))
        accumulator_reg <= pwdata[7:0];
      if (bus_write && is_reg(paddr, FLAGS_OFFSET))
        flags_reg <= pwdata[3:0];
    end
  end

  // Data memory; a bus write to the same byte wins over the instruction
  always_ff @(posedge clk) begin
    if (execute) begin
      unique case (op_issue.op)
        op_subtract_with_borrow_to_mem, op_subtract_to_mem: dmem[op_issue.addr] <= sub_res[11:4];
        op_decrement_skip_zero: dmem[op_issue.addr] <= dec_val;
        op_increment_skip_zero: dmem[op_issue.addr] <= inc_val;
        op_set_byte: dmem[op_issue.addr] <= BYTE_ONES;
        op_set_bit: dmem[op_issue.addr][op_issue.bit_sel] <= 1'b1;
        op_nibble_swap: dmem[op_issue.addr] <= swap_val;
        op_exclusive_or_to_mem: dmem[op_issue.addr] <= xor_val;
        default: ;
      endcase
    end
    // low byte of program word to memory
    if (state_reg == st_table_capture)
      dmem[table_dest_reg] <= pm_rdata[7:0];
    if (bus_write && paddr[APB_ADDR_W-1:DMEM_REGION_LSB] == DMEM_REGION)
      dmem[paddr[9:2]] <= pwdata[7:0];
  end

  // Skip and squash sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      squash_pending_reg <= 1'b0;
      skip_taken_reg     <= 1'b0;
      op_squashed_reg    <= 1'b0;
    end else begin
      // skip marks the next instruction as the dummy cycle
      skip_taken_reg  <= execute & skip_now;
      // the instruction after a skip executes as a no-operation
      op_squashed_reg <= accept & squash_pending_reg;
      if (execute)
        squash_pending_reg <= skip_now;
      else if (accept)
        squash_pending_reg <= 1'b0;
    end
  end

  // Table read sequencing
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg                <= st_idle;
      op_ready_reg             <= 1'b1;
      pm_rd_en_reg             <= 1'b0;
      pm_addr_reg              <= '0;
      table_dest_reg           <= BYTE_ZERO;
      table_read_high_byte_reg <= '0;
    end else begin
      pm_rd_en_reg <= 1'b0;
      unique case (state_reg)
        st_idle: begin
          if (execute && (op_issue.op == op_table_read_specific_page ||
                          op_issue.op == op_table_read_current_page ||
                          op_issue.op == op_table_read_last_page)) begin
            state_reg      <= st_table_fetch;
            op_ready_reg   <= 1'b0;
            pm_rd_en_reg   <= 1'b1;
            table_dest_reg <= op_issue.addr;
            unique case (op_issue.op)
              op_table_read_specific_page: pm_addr_reg <= {table_pointer_high, table_pointer_low};
              op_table_read_current_page:  pm_addr_reg <= {pc_page, table_pointer_low};
              default:                     pm_addr_reg <= {LAST_PAGE, table_pointer_low};
            endcase
          end
        end
        st_table_fetch: state_reg <= st_table_capture;
        st_table_capture: begin
          // high byte to the table-high register
          table_read_high_byte_reg <= pm_rdata[PM_DATA_W-1:8];
          state_reg                <= st_idle;
          op_ready_reg             <= 1'b1;
        end
      endcase
    end
  end

  // Table pointers, written by software
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      table_pointer_low  <= TPTR_RESET;
      table_pointer_high <= '0;
    end else if (bus_write && is_reg(paddr, TPTR_OFFSET)) begin
      table_pointer_low  <= pwdata[TPTR_LOW_LSB +: 8];
      table_pointer_high <= pwdata[TPTR_HIGH_LSB +: PM_ADDR_W-8];
    end
  end

  // APB slave: zero wait states, read data captured in the setup cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= WORD_ZERO;
    end else begin
      pready_reg  <= psel & ~penable;
      pslverr_reg <= 1'b0;
      if (psel && !penable) begin
        prdata_reg <= WORD_ZERO;
        if (is_reg(paddr, ACC_OFFSET))
          prdata_reg[7:0] <= accumulator_reg;
        else if (is_reg(paddr, FLAGS_OFFSET))
          prdata_reg[3:0] <= flags_reg;
        else if (is_reg(paddr, TPTR_OFFSET)) begin
          prdata_reg[TPTR_LOW_LSB +: 8]            <= table_pointer_low;
          prdata_reg[TPTR_HIGH_LSB +: PM_ADDR_W-8] <= table_pointer_high;
        end else if (is_reg(paddr, TABLE_READ_HIGH_BYTE_OFFSET))
          prdata_reg[PM_DATA_W-9:0] <= table_read_high_byte_reg;
        else if (is_reg(paddr, STATE_OFFSET)) begin
          prdata_reg[STATE_READY_BIT]  <= op_ready_reg;
          prdata_reg[STATE_SQUASH_BIT] <= squash_pending_reg;
        end else if (paddr[APB_ADDR_W-1:DMEM_REGION_LSB] == DMEM_REGION)
          prdata_reg[7:0] <= dmem[paddr[9:2]];
        else
          pslverr_reg <= 1'b1;
      end
    end
  end

  assign prdata               = prdata_reg;
  assign pready               = pready_reg;
  assign pslverr              = pslverr_reg;
  assign op_ready             = op_ready_reg;
  assign skip_taken           = skip_taken_reg;
  assign op_squashed          = op_squashed_reg;
  assign pm_rd_en             = pm_rd_en_reg;
  assign pm_addr              = pm_addr_reg;
  assign accumulator          = accumulator_reg;
  assign flags                = flags_reg;
  assign table_read_high_byte = table_read_high_byte_reg;

  logic quiet;
  assign quiet = ~(psel & penable);

  a_rotate_carry: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_rotate_right_carry_to_acc && quiet |=>
      accumulator_reg == {$past(flags_reg.carry_flag), $past(operand[7:1])} &&
      flags_reg.carry_flag == $past(operand[0]))
    else $error("rotate through carry wrong");

  a_sub_carry_sign: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_subtract && quiet |=>
      flags_reg.carry_flag == ($past(accumulator_reg) >= $past(operand)))
    else $error("subtract carry wrong");

  a_borrow_mem_write: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_subtract_with_borrow_to_mem && quiet |=>
      dmem[$past(op_issue.addr)] == 8'($past(accumulator_reg) - $past(operand) -
                                       {7'h00, ~$past(flags_reg.carry_flag)}))
    else $error("borrow subtract to memory wrong");

  a_dec_skip_zero: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_decrement_skip_zero |=>
      skip_taken_reg == ($past(operand) == BYTE_ONE) && $stable(flags_reg))
    else $error("decrement skip wrong");

  a_inc_acc_skip: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_increment_to_acc_skip_zero && quiet |=>
      accumulator_reg == 8'($past(operand) + BYTE_ONE) &&
      skip_taken_reg == ($past(operand) == BYTE_ONES))
    else $error("increment to accumulator skip wrong");

  a_set_byte_ones: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_set_byte && quiet |=>
      dmem[$past(op_issue.addr)] == BYTE_ONES && $stable(flags_reg))
    else $error("set byte wrong");

  a_squash_no_change: assert property (@(posedge clk) disable iff (!rst_n)
    accept && squash_pending_reg && quiet |=>
      $stable(accumulator_reg) && $stable(flags_reg) && op_squashed_reg && !skip_taken_reg)
    else $error("discarded instruction changed state");

  a_xor_zero_only: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_exclusive_or && quiet |=>
      accumulator_reg == $past(xor_val) && flags_reg.carry_flag == $past(flags_reg.carry_flag)
      && flags_reg.zero_flag == ($past(xor_val) == BYTE_ZERO))
    else $error("xor result or flags wrong");

  a_table_high_byte: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_table_read_specific_page |=>
      pm_rd_en_reg && pm_addr_reg == $past({table_pointer_high, table_pointer_low}) &&
      !op_ready_reg ##1 !op_ready_reg ##1
      op_ready_reg && table_read_high_byte_reg == $past(pm_rdata[PM_DATA_W-1:8]))
    else $error("table read sequence wrong");

  a_swap_acc: assert property (@(posedge clk) disable iff (!rst_n)
    execute && op_issue.op == op_nibble_swap_to_acc && quiet |=>
      accumulator_reg == {$past(operand[3:0]), $past(operand[7:4])})
    else $error("nibble swap to accumulator wrong");

endmodule : instr_exec_unit

/* File: mcu_instruction_semantics_bench.sv */
// Self-checking bench for the instruction execution unit
module mcu_instruction_semantics_bench
  import exec_unit_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic        op_valid, op_ready, pm_rd_en, e_skip;
  logic [11:0] paddr, pm_addr;
  logic [31:0] pwdata, prdata, seed;
  logic [15:0] pm_rdata;
  logic [3:0]  pc_page;
  logic [7:0]  e_acc, e_m, acc_out;
  flags_type   fl_out;
  logic [32:0] notes[$];
  issue_type   op_issue;
  flags_type   e_fl;
  int          n_fail, checks_done;

  instr_exec_unit dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_valid(op_valid), .op_issue(op_issue), .pc_page(pc_page), .op_ready(op_ready),
    .skip_taken(), .op_squashed(), .pm_rd_en(pm_rd_en), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .accumulator(acc_out), .flags(fl_out), .table_read_high_byte()
  );
  program_rom_model rom (.clk(clk), .rd_en(pm_rd_en), .addr(pm_addr), .rdata(pm_rdata));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_sim();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic hang(input string what);
    n_fail++;
    $display("CHECK FAILED at %0t: no %s", $time, what);
    end_sim();
  endtask

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [11:0] dm(input logic [7:0] n);
    return 12'h400 + {2'b00, n, 2'b00};
  endfunction

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) hang("pready");
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [32:0] e);
    notes.push_back(e);
    apb(1'b0, a, WORD_ZERO);
  endtask

  task automatic issue(input instr_op_type o, input logic [7:0] a, input logic [2:0] b,
                       input logic [7:0] im);
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (op_ready !== 1'b1 && i < 16);
    if (op_ready !== 1'b1) hang("op_ready");
    @(posedge clk);
    op_issue <= '{o, a, b, im};
    op_valid <= 1'b1;
    @(posedge clk);
    op_valid <= 1'b0;
  endtask

  task automatic sub(input logic [7:0] x, input logic bw, output logic [7:0] r);
    logic [8:0] d;
    logic [4:0] h;
    d = {1'b0, e_acc} - {1'b0, x} - {8'h00, bw};
    h = {1'b0, e_acc[3:0]} - {1'b0, x[3:0]} - {4'h0, bw};
    r = d[7:0];
    e_fl.carry_flag = ~d[8];
    e_fl.aux_carry_flag = ~h[4];
    e_fl.overflow_flag = (e_acc[7] != x[7]) && (r[7] != e_acc[7]);
    e_fl.zero_flag = (r == BYTE_ZERO);
  endtask

  task automatic model(input instr_op_type o, input logic [2:0] b, input logic [7:0] im);
    logic [7:0] m;
    m = e_m;
    e_skip = 1'b0;
    case (o)
      op_rotate_right_carry_to_acc:   {e_acc, e_fl.carry_flag} = {e_fl.carry_flag, m};
      op_subtract_with_borrow:        sub(m, ~e_fl.carry_flag, e_acc);
      op_subtract_with_borrow_to_mem: sub(m, ~e_fl.carry_flag, e_m);
      op_decrement_skip_zero:         {e_skip, e_m} = {m == BYTE_ONE, m - BYTE_ONE};
      op_decrement_to_acc_skip_zero:  {e_skip, e_acc} = {m == BYTE_ONE, m - BYTE_ONE};
      op_set_byte:                    e_m = BYTE_ONES;
      op_set_bit:                     e_m[b] = 1'b1;
      op_increment_skip_zero:         {e_skip, e_m} = {m == BYTE_ONES, m + BYTE_ONE};
      op_increment_to_acc_skip_zero:  {e_skip, e_acc} = {m == BYTE_ONES, m + BYTE_ONE};
      op_skip_bit_nonzero:            e_skip = m[b];
      op_subtract:                    sub(m, 1'b0, e_acc);
      op_subtract_imm:                sub(im, 1'b0, e_acc);
      op_subtract_to_mem:             sub(m, 1'b0, e_m);
      op_nibble_swap:                 e_m = {m[3:0], m[7:4]};
      op_nibble_swap_to_acc:          e_acc = {m[3:0], m[7:4]};
      op_skip_if_zero:                e_skip = (m == BYTE_ZERO);
      op_move_and_skip_zero:          {e_skip, e_acc} = {m == BYTE_ZERO, m};
      op_skip_bit_zero:               e_skip = ~m[b];
      op_exclusive_or:                {e_fl.zero_flag, e_acc} = {(e_acc ^ m) == 8'h00, e_acc ^ m};
      op_exclusive_or_imm:            {e_fl.zero_flag, e_acc} = {(e_acc ^ im) == 8'h00, e_acc ^ im};
      op_exclusive_or_to_mem:         {e_fl.zero_flag, e_m} = {(e_acc ^ m) == 8'h00, e_acc ^ m};
      default: ;
    endcase
  endtask

  // Compares each read answer with the oldest note
  always @(negedge clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0) begin
      checks_done++;
      if (notes.size() == 0 || {pslverr, prdata} !== notes[0]) begin
        n_fail++;
        $display("CHECK FAILED at %0t: read %h gave %h", $time, paddr, {pslverr, prdata});
      end
      if (notes.size() > 0) void'(notes.pop_front());
    end
  end

  initial begin
    int p, k;
    instr_op_type o;
    logic [7:0] a, im;
    logic [2:0] b;
    logic [11:0] t;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = WORD_ZERO;
    op_valid = 1'b0;
    op_issue = '0;
    pc_page = 4'h0;
    n_fail = 0;
    checks_done = 0;
    seed = 32'd71;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rd(STATE_OFFSET, 33'h000000001);
    rd(12'h020, {1'b1, WORD_ZERO});
    for (p = 0; p < 4; p++) begin
      for (k = 1; k <= 24; k++) begin
        o = instr_op_type'(k);
        if (o >= op_table_read_specific_page && o <= op_table_read_last_page) continue;
        a = 8'(rnd());
        b = 3'(rnd());
        im = 8'(rnd());
        e_acc = 8'(rnd());
        e_fl = 4'(rnd());
        e_m = (p == 0) ? BYTE_ZERO : (p == 1) ? BYTE_ONE : (p == 2) ? BYTE_ONES : 8'(rnd());
        apb(1'b1, ACC_OFFSET, {24'h0, e_acc});
        apb(1'b1, FLAGS_OFFSET, {28'h0, e_fl});
        apb(1'b1, dm(a), {24'h0, e_m});
        issue(o, a, b, im);
        model(o, b, im);
        rd(ACC_OFFSET, {25'h0, e_acc});
        rd(FLAGS_OFFSET, {29'h0, e_fl});
        rd(dm(a), {25'h0, e_m});
        rd(STATE_OFFSET, {31'h0, e_skip, 1'b1});
        checks_done++;
        if ({acc_out, fl_out} !== {e_acc, e_fl}) begin
          n_fail++;
          $display("CHECK FAILED at %0t: accumulator or flags output %h", $time, acc_out);
        end
        issue(op_set_byte, a, b, im);
        if (!e_skip) e_m = BYTE_ONES;
        rd(dm(a), {25'h0, e_m});
      end
    end
    for (k = 0; k < 6; k++) begin
      o = instr_op_type'(19 + k % 3);
      a = 8'(rnd());
      t = 12'(rnd());
      pc_page <= 4'(rnd());
      apb(1'b1, TPTR_OFFSET, {20'h0, t});
      issue(o, a, 3'h0, 8'h00);
      // Let the table capture land before the read samples memory
      repeat (2) @(posedge clk);
      if (o == op_table_read_current_page) t[11:8] = pc_page;
      if (o == op_table_read_last_page) t[11:8] = 4'hf;
      rd(dm(a), {25'h0, t[11:4] ^ {t[3:0], t[11:8]}});
      rd(TABLE_READ_HIGH_BYTE_OFFSET, {25'h0, t[7:0] ^ 8'h3c});
    end
    end_sim();
  end
endmodule // mcu_instruction_semantics_bench

/* File: program_rom_model.sv */
// Program memory model: one-cycle synchronous table ROM
module program_rom_model (
  input  wire logic        clk,
  input  wire logic        rd_en,
  input  wire logic [11:0] addr,
  output logic      [15:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial rdata = 16'h5a5a;

  // Word valid only in the cycle after a read; toggles otherwise
  always @(posedge clk) begin
    if (rd_en) begin
      rdata <= {addr[7:0] ^ 8'h3c, addr[11:4] ^ {addr[3:0], addr[11:8]}};
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule // program_rom_model
